// *** rtl/serial_ctrl_pkg.sv ***
// Functional notes
// - three-entry receive queue behind 8-bit shifter
// - byte transmit buffer, 20-bit loadable shift register
// - vector and master control shared; rest per-channel
// - data/command select high picks data registers
// - pointer write first, then register access
// - pointer clears after the following pointed access; data accesses keep it
// - vector unmodified on A, status-modified on B
// - pending bits readable only through channel A
// - divisor low/high bytes read back
// - three-bit misc command field decoded
// - status queue 10 by 19, 14-bit counter
// - closing flag pushes count plus five status
// - CRC checker reset at each frame end
// - ten unread frames held before overrun
// - queue active only when enabled and framed
// - queue pointers reset on disable and resets
// - any reset clears the queue enable bit
// - disabled queue images registers 4-7 onto 0-3
// - ext status info bit 2 shows enable
// - queue status, byte count, then status pops
// - overflow sets queue status MSB until re-enable
// - byte counter clears on flag, counts received chars
package serial_ctrl_pkg;
	// register indices, read side
	localparam logic [3:0] RD_MAIN_STATUS = 4'h0;
	localparam logic [3:0] RD_SPECIAL = 4'h1;
	localparam logic [3:0] RD_VECTOR = 4'h2;
	localparam logic [3:0] RD_PENDING = 4'h3;
	localparam logic [3:0] RD_IMAGE_LO = 4'h4;
	localparam logic [3:0] RD_IMAGE_HI = 4'h7;
	localparam logic [3:0] RD_BYTE_LOW = 4'h6;
	localparam logic [3:0] RD_QUEUE_STAT = 4'h7;
	localparam logic [3:0] RD_RX_BUF = 4'h8;
	localparam logic [3:0] RD_DIV_LOW = 4'hc;
	localparam logic [3:0] RD_DIV_HIGH = 4'hd;
	localparam logic [3:0] RD_EXT_INFO = 4'hf;
	// register indices, write side
	localparam logic [3:0] WR_COMMAND = 4'h0;
	localparam logic [3:0] WR_VECTOR = 4'h2;
	localparam logic [3:0] WR_SYNC_LO = 4'h6;
	localparam logic [3:0] WR_SYNC_HI = 4'h7;
	localparam logic [3:0] WR_TX_BUF = 4'h8;
	localparam logic [3:0] WR_MASTER = 4'h9;
	localparam logic [3:0] WR_LINE_CTRL = 4'ha;
	localparam logic [3:0] WR_DIV_LO = 4'hc;
	localparam logic [3:0] WR_DIV_HI = 4'hd;
	localparam logic [3:0] WR_MISC_CMD = 4'he;
	localparam logic [3:0] WR_EXT_CTRL = 4'hf;
	// command register fields
	localparam int CMD_LSB = 3;
	localparam logic [2:0] CMD_POINT_HIGH = 3'h1;
	localparam logic [2:0] CMD_ERR_RESET = 3'h6;
	// misc control command field
	localparam int MISC_CMD_LSB = 5;
	typedef enum logic [2:0] {
		MC_NULL = 3'h0,
		MC_SEARCH = 3'h1,
		MC_RST_MISSING = 3'h2,
		MC_DPLL_OFF = 3'h3,
		MC_SRC_BRG = 3'h4,
		MC_SRC_CLK_PIN = 3'h5,
		MC_FM = 3'h6,
		MC_NRZI = 3'h7
	} misc_cmd_t;
	// field positions
	localparam int EXT_QUEUE_EN_BIT = 2;
	localparam int QS_OVF_BIT = 7;
	localparam int QS_AVAIL_BIT = 6;
	localparam int SC_CRC_BIT = 6;
	localparam int SC_OVR_BIT = 5;
	localparam int SC_RES_LSB = 1;
	localparam int VEC_STAT_LSB = 1;
	// sizes
	localparam int SQ_DEPTH = 10;
	localparam int SQ_WIDTH = 19;
	localparam int SQ_AW = 4;
	localparam int BC_WIDTH = 14;
	localparam int TX_SHIFT_W = 20;
	localparam logic [SQ_AW-1:0] SQ_LAST = 4'h9;
	localparam logic [SQ_AW-1:0] SQ_FULL_CNT = 4'ha;
	localparam logic [1:0] RXQ_FULL = 2'h3;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

// *** rtl/status_queue_mem.sv ***
`timescale 1ns/10ps
module status_queue_mem
	import serial_ctrl_pkg::*;
#(
	parameter int W = SQ_WIDTH,
	parameter int D = SQ_DEPTH,
	parameter int AW = SQ_AW
) (
	input wire logic mclk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata_r
);
	logic [W-1:0] mem [D];

	// read data registered every cycle; head lags a pointer move by one
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_r <= mem[raddr];
	end
endmodule

// *** rtl/serial_ctrl_regs.sv ***
`timescale 1ns/10ps
module serial_ctrl_regs
	import serial_ctrl_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic chan_a_sel,
	input wire logic data_sel,
	input wire logic [7:0] din,
	output logic [7:0] dout,
	output logic dout_oe,
	input wire logic [1:0] chan_rst,
	input wire logic [1:0] sdlc_mode,
	input wire logic [1:0] rx_char_valid,
	input wire logic [1:0][7:0] rx_char,
	input wire logic [1:0] rx_flag,
	input wire logic [1:0] rx_eof,
	input wire logic [1:0][7:0] rx_status,
	input wire logic [1:0][7:0] ext_status,
	input wire logic [2:0] irq_status,
	input wire logic [5:0] irq_pending_bit,
	input wire logic [1:0] tx_load,
	input wire logic [1:0] tx_shift_en,
	output logic [1:0] tx_data_out,
	output logic [1:0] tx_buf_empty,
	output logic [1:0] crc_reset,
	output logic [1:0][6:0] misc_cmd_pulse,
	output logic [1:0][7:0] misc_line_control,
	output logic [7:0] master_irq_control_reg,
	output logic [7:0] vector_write_reg
);
	typedef struct packed {
		logic [3:0] ptr;
		logic [7:0] sync_lo;
		logic [7:0] sync_hi;
		logic [7:0] line_ctrl;
		logic [7:0] div_lo;
		logic [7:0] div_hi;
		logic [7:0] ext_ctrl;
		logic [2:0][7:0] rxq;
		logic [1:0] rx_cnt;
		logic rx_ovr;
		logic [7:0] tx_buf;
		logic tx_full;
		logic [TX_SHIFT_W-1:0] tx_shift;
		logic [BC_WIDTH-1:0] bc;
		logic [SQ_AW-1:0] wp;
		logic [SQ_AW-1:0] rp;
		logic [SQ_AW-1:0] cnt;
		logic sq_ovf;
		logic crc_rst;
		logic [6:0] mcmd;
	} chan_t;

	typedef struct packed {
		logic [2:0] cs_s;
		logic [2:0] rd_s;
		logic [2:0] wr_s;
		logic [1:0] asel_s;
		logic [1:0] dc_s;
		logic [1:0][7:0] din_s;
		logic [7:0] dout;
		logic dout_oe;
		logic [7:0] vector;
		logic [7:0] master;
		chan_t [1:0] ch;
	} st_t;

	st_t s_r;
	st_t s_nxt;
	logic [1:0] sq_we;
	logic [1:0][SQ_WIDTH-1:0] sq_wdata;
	logic [1:0][SQ_WIDTH-1:0] sq_head;

	// one status memory per channel
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_sq
			status_queue_mem #(
				.W(SQ_WIDTH),
				.D(SQ_DEPTH),
				.AW(SQ_AW)
			) u_mem (
				.mclk(mclk),
				.we(sq_we[g]),
				.waddr(s_r.ch[g].wp),
				.wdata(sq_wdata[g]),
				.raddr(s_r.ch[g].rp),
				.rdata_r(sq_head[g])
			);
		end
	endgenerate

	always_comb begin
		logic rd_go;
		logic wr_go;
		logic c;
		logic [3:0] idx;
		logic [7:0] val;
		logic [7:0] wd;
		logic [1:0] en;
		logic [1:0] from_q;
		logic [1:0] pop_sq;
		logic [1:0] pop_rx;
		logic [1:0] wr_tx;
		s_nxt = s_r;
		rd_go = 1'b0;
		wr_go = 1'b0;
		c = 1'b0;
		idx = 4'h0;
		val = 8'h00;
		wd = 8'h00;
		en = 2'b00;
		from_q = 2'b00;
		pop_sq = 2'b00;
		pop_rx = 2'b00;
		wr_tx = 2'b00;
		sq_we = 2'b00;
		sq_wdata = '0;

		// pins cross into mclk through two flops before use
		s_nxt.cs_s = {s_r.cs_s[1:0], cs_n};
		s_nxt.rd_s = {s_r.rd_s[1:0], rd_n};
		s_nxt.wr_s = {s_r.wr_s[1:0], wr_n};
		s_nxt.asel_s = {s_r.asel_s[0], chan_a_sel};
		s_nxt.dc_s = {s_r.dc_s[0], data_sel};
		s_nxt.din_s = {s_r.din_s[0], din};

		rd_go = ~s_r.rd_s[1] & s_r.rd_s[2] & ~s_r.cs_s[1];
		wr_go = ~s_r.wr_s[1] & s_r.wr_s[2] & ~s_r.cs_s[1];
		c = ~s_r.asel_s[1];
		wd = s_r.din_s[1];

		for (int i = 0; i < 2; i++) begin
			// queue is read only while enabled and holding a frame
			en[i] = s_r.ch[i].ext_ctrl[EXT_QUEUE_EN_BIT] & sdlc_mode[i];
			from_q[i] = en[i] & (s_r.ch[i].cnt != 4'h0);
		end

		// host read: data select bypasses the pointer
		if (rd_go) begin
			idx = s_r.dc_s[1] ? RD_RX_BUF : s_r.ch[c].ptr;
			// enabled queue keeps 6 and 7 for count and queue status
			if (!en[c] && idx >= RD_IMAGE_LO && idx <= RD_IMAGE_HI) begin
				idx = idx - RD_IMAGE_LO;
			end else if (en[c] && idx < RD_BYTE_LOW && idx >= RD_IMAGE_LO) begin
				idx = idx - RD_IMAGE_LO;
			end
			unique case (idx)
				RD_MAIN_STATUS: val = {ext_status[c][7:3], ~s_r.ch[c].tx_full,
					ext_status[c][1], s_r.ch[c].rx_cnt != 2'h0};
				RD_SPECIAL: begin
					val = rx_status[c];
					// overrun belongs to the data queue, not the live bits
					val[SC_OVR_BIT] = s_r.ch[c].rx_ovr;
					// queued status only where a frame is waiting
					if (from_q[c]) begin
						val[SC_CRC_BIT] = sq_head[c][0];
						val[SC_OVR_BIT] = sq_head[c][1];
						val[SC_RES_LSB +: 3] = sq_head[c][4:2];
						pop_sq[c] = 1'b1;
					end
				end
				RD_VECTOR: begin
					// status replaces bits 3:1 only when read through B
					val = s_r.vector;
					if (c) begin
						val[VEC_STAT_LSB +: 3] = irq_status;
					end
				end
				RD_PENDING: val = c ? 8'h00 : {2'b00, irq_pending_bit};
				RD_BYTE_LOW: val = from_q[c] ? sq_head[c][12:5] :
					s_r.ch[c].bc[7:0];
				RD_QUEUE_STAT: val = {s_r.ch[c].sq_ovf, from_q[c],
					from_q[c] ? sq_head[c][18:13] : s_r.ch[c].bc[13:8]};
				RD_RX_BUF: begin
					val = s_r.ch[c].rxq[0];
					pop_rx[c] = 1'b1;
				end
				RD_DIV_LOW: val = s_r.ch[c].div_lo;
				RD_DIV_HIGH: val = s_r.ch[c].div_hi;
				RD_EXT_INFO: val = {s_r.ch[c].ext_ctrl[7:3], en[c],
					s_r.ch[c].ext_ctrl[1:0]};
				default: val = 8'h00;
			endcase
			s_nxt.dout = val;
			s_nxt.dout_oe = 1'b1;
			// data reads leave a pending pointer alone
			if (!s_r.dc_s[1]) begin
				s_nxt.ch[c].ptr = 4'h0;
			end
		end else if (s_r.rd_s[1] || s_r.cs_s[1]) begin
			s_nxt.dout_oe = 1'b0;
		end

		// host write
		if (wr_go) begin
			idx = s_r.dc_s[1] ? WR_TX_BUF : s_r.ch[c].ptr;
			if (idx == WR_COMMAND) begin
				// point-high command reaches the upper eight registers
				s_nxt.ch[c].ptr = {wd[CMD_LSB +: 3] == CMD_POINT_HIGH,
					wd[2:0]};
				if (wd[CMD_LSB +: 3] == CMD_ERR_RESET) begin
					s_nxt.ch[c].rx_ovr = 1'b0;
				end
			end else begin
				// a data write must not consume a pending pointer
				if (!s_r.dc_s[1]) begin
					s_nxt.ch[c].ptr = 4'h0;
				end
				unique case (idx)
					WR_VECTOR: s_nxt.vector = wd;
					WR_MASTER: s_nxt.master = wd;
					WR_SYNC_LO: s_nxt.ch[c].sync_lo = wd;
					WR_SYNC_HI: s_nxt.ch[c].sync_hi = wd;
					WR_TX_BUF: wr_tx[c] = 1'b1;
					WR_LINE_CTRL: s_nxt.ch[c].line_ctrl = wd;
					WR_DIV_LO: s_nxt.ch[c].div_lo = wd;
					WR_DIV_HI: s_nxt.ch[c].div_hi = wd;
					WR_EXT_CTRL: s_nxt.ch[c].ext_ctrl = wd;
					WR_MISC_CMD: begin
						// one pulse per command, null gives none
						if (wd[MISC_CMD_LSB +: 3] != MC_NULL) begin
							s_nxt.ch[c].mcmd[wd[MISC_CMD_LSB +: 3] - 3'h1] =
								1'b1;
						end
					end
					default: ;
				endcase
			end
		end

		for (int i = 0; i < 2; i++) begin
			s_nxt.ch[i].crc_rst = 1'b0;
			// misc command pulses last a single cycle
			if (!(wr_go && c == i[0] && idx == WR_MISC_CMD)) begin
				s_nxt.ch[i].mcmd = 7'h00;
			end

			// receive queue: host pop first, then the shifter's char
			if (pop_rx[i] && s_r.ch[i].rx_cnt != 2'h0) begin
				s_nxt.ch[i].rxq = {8'h00, s_r.ch[i].rxq[2:1]};
				s_nxt.ch[i].rx_cnt = s_r.ch[i].rx_cnt - 2'h1;
			end
			if (rx_char_valid[i]) begin
				if (s_nxt.ch[i].rx_cnt == RXQ_FULL) begin
					s_nxt.ch[i].rx_ovr = 1'b1;
				end else begin
					s_nxt.ch[i].rxq[s_nxt.ch[i].rx_cnt] = rx_char[i];
					s_nxt.ch[i].rx_cnt = s_nxt.ch[i].rx_cnt + 2'h1;
				end
			end

			// transmitter: load uses the old buffer before a new write
			if (tx_load[i]) begin
				s_nxt.ch[i].tx_shift = s_r.ch[i].tx_full ?
					{12'h000, s_r.ch[i].tx_buf} :
					{4'h0, s_r.ch[i].sync_hi, s_r.ch[i].sync_lo};
				s_nxt.ch[i].tx_full = 1'b0;
			end else if (tx_shift_en[i]) begin
				s_nxt.ch[i].tx_shift = {1'b0,
					s_r.ch[i].tx_shift[TX_SHIFT_W-1:1]};
			end
			if (wr_tx[i]) begin
				s_nxt.ch[i].tx_buf = wd;
				s_nxt.ch[i].tx_full = 1'b1;
			end

			// frame byte counter
			if (sdlc_mode[i]) begin
				// a char beside the flag opens the next count
				if (rx_flag[i]) begin
					s_nxt.ch[i].bc = rx_char_valid[i] ? 14'h0001 : 14'h0000;
				end else if (rx_char_valid[i]) begin
					s_nxt.ch[i].bc = s_r.ch[i].bc + 14'h0001;
				end
				s_nxt.ch[i].crc_rst = rx_eof[i];
			end

			// status queue
			if (!en[i]) begin
				s_nxt.ch[i].wp = '0;
				s_nxt.ch[i].rp = '0;
				s_nxt.ch[i].cnt = '0;
				// only a disable or a reset drops a latched overflow
				s_nxt.ch[i].sq_ovf = 1'b0;
			end else begin
				if (pop_sq[i]) begin
					s_nxt.ch[i].rp = (s_r.ch[i].rp == SQ_LAST) ? '0 :
						s_r.ch[i].rp + 4'h1;
					s_nxt.ch[i].cnt = s_r.ch[i].cnt - 4'h1;
				end
				if (rx_eof[i]) begin
					// a pop in the same cycle frees a slot first
					if (s_nxt.ch[i].cnt == SQ_FULL_CNT) begin
						s_nxt.ch[i].sq_ovf = 1'b1;
					end else begin
						sq_we[i] = 1'b1;
						sq_wdata[i] = {s_r.ch[i].bc,
							rx_status[i][SC_RES_LSB +: 3],
							s_r.ch[i].rx_ovr,
							rx_status[i][SC_CRC_BIT]};
						s_nxt.ch[i].wp = (s_r.ch[i].wp == SQ_LAST) ? '0 :
							s_r.ch[i].wp + 4'h1;
						s_nxt.ch[i].cnt = s_nxt.ch[i].cnt + 4'h1;
					end
				end
			end

			// channel reset last so it overrides every event
			if (chan_rst[i]) begin
				s_nxt.ch[i] = '0;
			end
		end
	end

	// power-on reset zeroes everything but the strobe syncs, which load ones; queue enable included
	always_ff @(posedge mclk) begin
		if (srst) begin
			s_r <= '0;
			s_r.cs_s <= 3'h7;
			s_r.rd_s <= 3'h7;
			s_r.wr_s <= 3'h7;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dout = s_r.dout;
	assign dout_oe = s_r.dout_oe;
	assign master_irq_control_reg = s_r.master;
	assign vector_write_reg = s_r.vector;

	generate
		for (g = 0; g < 2; g++) begin : g_out
			assign tx_data_out[g] = s_r.ch[g].tx_shift[0];
			assign tx_buf_empty[g] = ~s_r.ch[g].tx_full;
			assign crc_reset[g] = s_r.ch[g].crc_rst;
			assign misc_cmd_pulse[g] = s_r.ch[g].mcmd;
			assign misc_line_control[g] = s_r.ch[g].line_ctrl;
		end
	endgenerate
endmodule

// *** rtl/dummy_unused_none.sv ***
`timescale 1ns/10ps

// *** verif/serial_ctrl_regs_checker.sv ***
`timescale 1ns/10ps
module serial_ctrl_regs_checker (
	input wire logic mclk,
	input wire logic srst,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic dout_oe,
	input wire logic [1:0] chan_rst,
	input wire logic [1:0] sdlc_mode,
	input wire logic [1:0] rx_eof,
	input wire logic [1:0] crc_reset,
	input wire logic [1:0] tx_load,
	input wire logic [1:0] tx_buf_empty,
	input wire logic [1:0][6:0] misc_cmd_pulse,
	input wire logic [7:0] vector_write_reg
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	a_oe_needs_rd: assert property ($rose(dout_oe) |-> !$past(rd_n, 2))
		else $error("bus driven without read");
	a_oe_let_go: assert property ($rose(rd_n) |-> ##[1:5] !dout_oe)
		else $error("bus held after read");
	a_crc_on_eof: assert property (rx_eof[0] && sdlc_mode[0] && !chan_rst[0]
		|=> crc_reset[0])
		else $error("no crc reset after frame end");
	a_crc_cause: assert property (crc_reset[1]
		|-> $past(rx_eof[1]) && $past(sdlc_mode[1]))
		else $error("crc reset without frame end");
	a_misc_onehot: assert property ($onehot0(misc_cmd_pulse[0]))
		else $error("misc command not one-hot");
	a_misc_single: assert property (misc_cmd_pulse[0] != 7'h00
		|=> misc_cmd_pulse[0] == 7'h00)
		else $error("misc command pulse too long");
	a_misc_from_wr: assert property (misc_cmd_pulse[0] != 7'h00
		|-> !$past(wr_n, 2))
		else $error("misc command without write");
	a_load_empties: assert property (tx_load[0] && !chan_rst[0]
		|=> tx_buf_empty[0])
		else $error("buffer not empty after load");
	a_vec_from_wr: assert property (!$stable(vector_write_reg)
		&& !$past(srst) |-> !$past(wr_n))
		else $error("vector changed without write");
endmodule

// *** verif/host_bus_model.sv ***
`timescale 1ns/10ps
module host_bus_model
	import serial_ctrl_pkg::*;
(
	input wire logic mclk,
	output logic cs_n,
	output logic rd_n,
	output logic wr_n,
	output logic chan_a_sel,
	output logic data_sel,
	output logic [7:0] din,
	input wire logic [7:0] dout
);
	initial {cs_n, rd_n, wr_n, chan_a_sel, data_sel, din} = 13'h1f00;
	// strobe held 6 cycles: sync takes 2, answer one more
	task automatic acc(input logic w, a, d, input logic [7:0] wd,
		output logic [7:0] q);
		@(posedge mclk);
		cs_n <= 1'b0;
		chan_a_sel <= a;
		data_sel <= d;
		din <= w ? wd : ~din;
		repeat (2) @(posedge mclk);
		rd_n <= w;
		wr_n <= !w;
		repeat (6) @(posedge mclk);
		q = dout;
		{rd_n, wr_n} <= 2'b11;
		repeat (4) @(posedge mclk);
		cs_n <= 1'b1;
		// released bus: never leave the last value showing
		din <= ~din;
	endtask
	task automatic ra(input logic w, a, input logic [3:0] i,
		input logic [7:0] wd, output logic [7:0] q);
		acc(1'b1, a, 1'b0,
			{2'b00, i[3] ? CMD_POINT_HIGH : 3'h0, i[2:0]}, q);
		acc(w, a, 1'b0, wd, q);
	endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/10ps
module tb
	import serial_ctrl_pkg::*;
;
	localparam logic CHA = 1'b1;
	localparam logic CHB = 1'b0;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic cs_n, rd_n, wr_n, chan_a_sel, data_sel, dout_oe;
	logic [7:0] din, dout, master_irq_control_reg, vector_write_reg;
	logic [1:0] chan_rst, sdlc_mode, rx_char_valid, rx_flag, rx_eof;
	logic [1:0] tx_load, tx_shift_en, tx_data_out, tx_buf_empty, crc_reset;
	logic [1:0][7:0] rx_char, rx_status, ext_status, misc_line_control;
	logic [1:0][6:0] misc_cmd_pulse;
	logic [2:0] irq_status;
	logic [5:0] irq_pending_bit;
	logic [6:0] seen;
	logic [7:0] q, q2, v, n[0:10], st[0:10], c[0:3];
	logic [31:0] rs = 32'hd83542a6;
	int fails, checks, cyc;
	serial_ctrl_regs DUT (.*);
	host_bus_model host (.*);
	always #25 mclk = ~mclk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// CRC and residue from the entry, overrun bit 5 expected zero, the rest stays live
	function automatic logic [7:0] sc_exp(input logic [7:0] e, l);
		return (e & 8'h4e) | (l & 8'h91);
	endfunction
	task automatic cmp(input logic [7:0] got, exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		if (fails == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic a, input logic [3:0] i,
		input logic [7:0] m, e);
		host.ra(1'b0, a, i, 8'h00, q);
		cmp(q & m, e);
	endtask
	task automatic wr(input logic a, input logic [3:0] i, input logic [7:0] d);
		host.ra(1'b1, a, i, d, q);
	endtask
	task automatic chr(input logic [7:0] d);
		@(posedge mclk);
		rx_char[0] <= d;
		rx_char_valid <= 2'b01;
		@(posedge mclk);
		rx_char_valid <= 2'b00;
	endtask
	// drained per frame so the data queue never overruns
	task automatic frames(input int cnt);
		for (int k = 0; k < cnt; k++) begin
			rs = lfsr(rs);
			n[k] = {6'h00, rs[1:0]};
			st[k] = {1'b0, rs[8], 2'b00, rs[4:2], 1'b0};
			rx_status[0] <= st[k];
			repeat (n[k]) chr(rs[31:24]);
			@(posedge mclk);
			{rx_eof, rx_flag} <= 4'hd;
			@(posedge mclk);
			{rx_eof, rx_flag} <= 4'h0;
			repeat (n[k]) host.acc(1'b0, CHA, 1'b1, 8'h00, q);
		end
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (misc_cmd_pulse[0] != 7'h00)
			seen <= misc_cmd_pulse[0];
		if (cyc == 20000) begin
			fails++;
			give_verdict;
		end
	end
	initial begin
		{chan_rst, sdlc_mode, rx_char_valid, rx_flag, rx_eof} = 10'h000;
		{tx_load, tx_shift_en, rx_char, rx_status} = 36'h0;
		{ext_status, irq_status, irq_pending_bit} = rs[24:0];
		seen = 7'h00;
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		repeat (3) @(posedge mclk);
		chk(CHA, RD_EXT_INFO, 8'h04, 8'h00);
		rs = lfsr(rs);
		v = rs[7:0];
		wr(CHB, WR_VECTOR, v);
		cmp(vector_write_reg, v);
		wr(CHB, WR_MASTER, ~v);
		cmp(master_irq_control_reg, ~v);
		chk(CHA, RD_VECTOR, 8'hff, v);
		chk(CHB, RD_VECTOR, 8'hff, {v[7:4], irq_status, v[0]});
		q2 = {ext_status[0][7:3], 1'b1, ext_status[0][1], 1'b0};
		host.acc(1'b0, CHA, 1'b0, 8'h00, q);
		cmp(q, q2);
		chk(CHA, RD_MAIN_STATUS, 8'hff, q2);
		chk(CHA, RD_PENDING, 8'hff, {2'b00, irq_pending_bit});
		chk(CHB, RD_PENDING, 8'hff, 8'h00);
		wr(CHA, WR_DIV_LO, v);
		wr(CHA, WR_DIV_HI, ~v);
		chk(CHA, RD_DIV_LOW, 8'hff, v);
		chk(CHA, RD_DIV_HIGH, 8'hff, ~v);
		wr(CHA, WR_LINE_CTRL, ~v);
		cmp(misc_line_control[0], ~v);
		for (int k = 0; k < 8; k++) begin
			seen = 7'h00;
			wr(CHA, WR_MISC_CMD, {k[2:0], 5'h00});
			cmp({1'b0, seen}, k ? 8'h01 << (k - 1) : 8'h00);
		end
		host.acc(1'b1, CHA, 1'b1, v, q);
		cmp({6'h00, tx_buf_empty}, 8'h02);
		tx_load <= 2'b01;
		@(posedge mclk);
		{tx_load, tx_shift_en} <= 4'h1;
		@(posedge mclk);
		tx_shift_en <= 2'b00;
		@(negedge mclk);
		cmp({7'h00, tx_data_out[0]}, {7'h00, v[1]});
		wr(CHA, WR_SYNC_LO, v);
		tx_load <= 2'b01;
		@(posedge mclk);
		tx_load <= 2'b00;
		@(negedge mclk);
		cmp({7'h00, tx_data_out[0]}, {7'h00, v[0]});
		for (int k = 0; k < 4; k++) begin
			rs = lfsr(rs);
			c[k] = rs[7:0];
			chr(c[k]);
		end
		chk(CHA, RD_SPECIAL, 8'h20, 8'h20);
		for (int k = 0; k < 3; k++) begin
			host.acc(1'b0, CHA, 1'b1, 8'h00, q);
			cmp(q, c[k]);
		end
		host.acc(1'b1, CHA, 1'b0, {2'b00, CMD_ERR_RESET, 3'h0}, q);
		chk(CHA, RD_SPECIAL, 8'h20, 8'h00);
		@(posedge mclk);
		{chan_rst, sdlc_mode} <= 4'h7;
		@(posedge mclk);
		chan_rst <= 2'b00;
		wr(CHA, WR_EXT_CTRL, 8'h04);
		chk(CHA, RD_EXT_INFO, 8'h04, 8'h04);
		frames(10);
		rx_status[0] <= 8'hd1;
		for (int k = 0; k < 10; k++) begin
			chk(CHA, RD_QUEUE_STAT, 8'hc0, 8'h40);
			chk(CHA, RD_BYTE_LOW, 8'hff, n[k]);
			chk(CHA, RD_SPECIAL, 8'hff, sc_exp(st[k], 8'hd1));
		end
		chk(CHA, RD_QUEUE_STAT, 8'hc0, 8'h00);
		chk(CHA, RD_SPECIAL, 8'hff, 8'hd1);
		frames(11);
		chk(CHA, RD_QUEUE_STAT, 8'h80, 8'h80);
		wr(CHA, WR_EXT_CTRL, 8'h00);
		chk(CHA, RD_IMAGE_HI, 8'hff, {2'b00, irq_pending_bit});
		chk(CHA, RD_BYTE_LOW, 8'hff, v);
		wr(CHA, WR_EXT_CTRL, 8'h04);
		chk(CHA, RD_QUEUE_STAT, 8'hc0, 8'h00);
		give_verdict;
	end
endmodule
bind serial_ctrl_regs serial_ctrl_regs_checker watch (.*);
